/* verilog/amr_top.v */
// Measurement, linear signal strength and anti-collision monitor top level
// Functional notes
// - Codes 7..A select supply voltages
// - Command 87h starts conversion of selection
// - Page 00b shows result at 2Dh
// - Supply code follows fixed linear transfer
// - Hold I/Q levels at pilot end
// - Codes B and C select held samples
// - Linear samples span -127 to +127
// - Status 2Ah shows subcarrier phase flag
// - Phase flag valid pilot end to rx end
// - Code 4 selects carrier level detector
// - Command AAh enables collision monitoring
// - Flag host when packet exceeds threshold; logic flags only the first exceedance after AAh, until ABh clears it
// - Store pilot, data and maximum levels
// - Store first, duration, violation bit positions
// - Threshold from 1Dh bits 3:0
// - Command ABh disables and clears data except pilot and data levels
// - Six-bit addresses, display registers read-only
// - Conversion done in 20 us, flag set
// - Result MSB sign, seven magnitude bits
`timescale 1ns/1ps
`default_nettype none

`include "amr_defines.vh"

module amr_top (
  input  wire       REF_CLK,       // 25 MHz block clock
  input  wire       RESET,         // Async reset, high
  input  wire       REG_WR,        // Register write strobe, one cycle
  input  wire       REG_RD,        // Register read strobe, one cycle
  input  wire [5:0] REG_ADDR,      // Register address
  input  wire [7:0] REG_WDATA,     // Register write data
  input  wire       CMD_STB,       // Direct command strobe, one cycle
  input  wire [7:0] CMD_CODE,      // Direct command code
  input  wire [7:0] AIN_CARRIER,   // Carrier level detector sample
  input  wire [7:0] AIN_EXT,       // External supply sample, 4 transfer applied
  input  wire [7:0] AIN_DIG,       // Internal digital supply sample
  input  wire [7:0] AIN_EXT_AMP,   // External amplifier supply sample
  input  wire [7:0] AIN_INT_AMP,   // Internal amplifier supply sample
  input  wire [7:0] AIN_OTHER,     // Any other source, by select code
  input  wire [7:0] LIN_I,         // I channel peak-to-peak level, 0 = min
  input  wire [7:0] LIN_Q,         // Q channel peak-to-peak level
  input  wire       SUBC_INPHASE,  // I and Q in phase, from detector
  input  wire [7:0] ENV_LEVEL,     // Received envelope level, upper nibble compared
  input  wire       RX_ACTIVE,     // Reception in progress
  input  wire       PILOT_END,     // Pilot tone end pulse
  input  wire       DATA_MARK,     // Data phase sampling pulse
  input  wire       BIT_TICK,      // One pulse per received bit
  input  wire       PROTO_ERR,     // Protocol violation pulse
  input  wire       IRQ_CLR,       // Second interrupt register read-clear
  output reg  [7:0] REG_RDATA,     // Read data
  output reg        RD_VALID,      // Read data valid, one cycle
  output reg  [3:0] SRC_SEL,       // Converter input selection
  output reg        IRQ            // Interrupt request level
);

  // ----------------------------------------------------------------------------
  // Synchronised detector inputs
  // ----------------------------------------------------------------------------
  wire [7:0] env_s;
  wire       rx_s;
  wire       pilot_s;
  wire       data_s;
  wire       tick_s;
  wire       err_s;
  wire       phase_s;
  wire       irqclr_s;

  amr_sync #(.W(15)) u_sync (
    .clk (REF_CLK),
    .rst (RESET),
    .d   ({ENV_LEVEL, RX_ACTIVE, PILOT_END, DATA_MARK, BIT_TICK, PROTO_ERR,
            SUBC_INPHASE, IRQ_CLR}),
    .q   ({env_s, rx_s, pilot_s, data_s, tick_s, err_s, phase_s, irqclr_s})
  );

  // Edge history so each pulse counts once
  reg pilot_d_reg;
  reg data_d_reg;
  reg tick_d_reg;
  reg err_d_reg;
  reg rx_d_reg;
  reg clr_d_reg;
  wire pilot_rise = pilot_s & ~pilot_d_reg;
  wire data_rise  = data_s & ~data_d_reg;
  wire tick_rise  = tick_s & ~tick_d_reg;
  wire err_rise   = err_s & ~err_d_reg;
  wire rx_fall    = ~rx_s & rx_d_reg;
  wire clr_rise   = irqclr_s & ~clr_d_reg;

  // ----------------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------------
  reg [7:0] meas_sel_reg;
  reg [7:0] coll_thr_reg;
  reg [7:0] page_sel_reg;
  wire [3:0] msel   = meas_sel_reg[`AMR_MSEL_HI:`AMR_MSEL_LO];
  wire [3:0] thr    = coll_thr_reg[`AMR_THR_HI:`AMR_THR_LO];
  wire [1:0] page2d = page_sel_reg[`AMR_PAGE2D_HI:`AMR_PAGE2D_LO];
  wire [3:0] page2b = page_sel_reg[`AMR_PAGE2B_HI:`AMR_PAGE2B_LO];

  // Only RW registers decode on write; display addresses fall through
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      meas_sel_reg <= `AMR_RST_MEAS_SEL;
      coll_thr_reg <= `AMR_RST_COLL_THR;
      page_sel_reg <= `AMR_RST_PAGE_SEL;
    end else if (REG_WR) begin
      if (REG_ADDR == `AMR_ADDR_MEAS_SEL) begin
        meas_sel_reg <= REG_WDATA;
      end else if (REG_ADDR == `AMR_ADDR_COLL_THR) begin
        coll_thr_reg <= REG_WDATA;
      end else if (REG_ADDR == `AMR_ADDR_PAGE_SEL) begin
        page_sel_reg <= REG_WDATA;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Linear sample and hold plus phase flag
  // ----------------------------------------------------------------------------
  reg [7:0] hold_i_reg;
  reg [7:0] hold_q_reg;
  reg       phase_reg;
  reg       phase_ok_reg;

  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      hold_i_reg   <= 8'h00;
      hold_q_reg   <= 8'h00;
      phase_reg    <= 1'b0;
      phase_ok_reg <= 1'b0;
    end else if (pilot_rise) begin
      hold_i_reg   <= LIN_I;
      hold_q_reg   <= LIN_Q;
      phase_reg    <= phase_s;
      phase_ok_reg <= 1'b1;
    end else if (rx_fall) begin
      phase_ok_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Source selection; linear levels map 0..254 onto -127..+127
  // ----------------------------------------------------------------------------
  reg [7:0] conv_in;
  always @* begin
    if (msel == `AMR_SRC_CARRIER) begin
      conv_in = AIN_CARRIER;
    end else if (msel == `AMR_SRC_EXT_SUPPLY) begin
      conv_in = AIN_EXT;
    end else if (msel == `AMR_SRC_DIG_SUPPLY) begin
      conv_in = AIN_DIG;
    end else if (msel == `AMR_SRC_EXT_AMP) begin
      conv_in = AIN_EXT_AMP;
    end else if (msel == `AMR_SRC_INT_AMP) begin
      conv_in = AIN_INT_AMP;
    end else if (msel == `AMR_SRC_LIN_I) begin
      conv_in = (hold_i_reg == 8'hff) ? 8'hff : hold_i_reg + 8'h01;
    end else if (msel == `AMR_SRC_LIN_Q) begin
      conv_in = (hold_q_reg == 8'hff) ? 8'hff : hold_q_reg + 8'h01;
    end else begin
      conv_in = AIN_OTHER;
    end
  end

  // ----------------------------------------------------------------------------
  // Converter
  // ----------------------------------------------------------------------------
  wire       conv_start = CMD_STB && (CMD_CODE == `AMR_CMD_CONVERT);
  wire       conv_busy;
  wire       conv_done;
  wire [7:0] conv_result;

  amr_adc_core u_adc (
    .clk    (REF_CLK),
    .rst    (RESET),
    .start  (conv_start),
    .sample (conv_in),
    .busy   (conv_busy),
    .done   (conv_done),
    .result (conv_result)
  );

  // ----------------------------------------------------------------------------
  // Collision monitor
  // ----------------------------------------------------------------------------
  reg        mon_reg;
  reg        above_reg;
  reg        seen_reg;
  reg        viol_seen_reg;
  reg [7:0]  pilot_lvl_reg;
  reg [7:0]  data_lvl_reg;
  reg [7:0]  max_lvl_reg;
  reg [7:0]  bitpos_reg;
  reg [7:0]  first_reg;
  reg [7:0]  dur_reg;
  reg [7:0]  viol_reg;
  wire       over = (env_s[7:4] > thr);
  wire       coll_off = CMD_STB && (CMD_CODE == `AMR_CMD_COLL_OFF);

  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      mon_reg       <= 1'b0;
      above_reg     <= 1'b0;
      seen_reg      <= 1'b0;
      viol_seen_reg <= 1'b0;
      pilot_lvl_reg <= 8'h00;
      data_lvl_reg  <= 8'h00;
      max_lvl_reg   <= 8'h00;
      bitpos_reg    <= 8'h00;
      first_reg     <= 8'h00;
      dur_reg       <= 8'h00;
      viol_reg      <= 8'h00;
    end else if (coll_off) begin
      mon_reg       <= 1'b0;
      above_reg     <= 1'b0;
      seen_reg      <= 1'b0;
      viol_seen_reg <= 1'b0;
      max_lvl_reg   <= 8'h00;
      bitpos_reg    <= 8'h00;
      first_reg     <= 8'h00;
      dur_reg       <= 8'h00;
      viol_reg      <= 8'h00;
    end else begin
      if (CMD_STB && (CMD_CODE == `AMR_CMD_COLL_ON)) begin
        mon_reg <= 1'b1;
      end
      if (mon_reg && rx_s) begin
        above_reg <= over;
        if (pilot_rise) begin
          pilot_lvl_reg <= env_s;
        end
        if (data_rise) begin
          data_lvl_reg <= env_s;
        end
        if (env_s > max_lvl_reg) begin
          max_lvl_reg <= env_s;
        end
        if (tick_rise && bitpos_reg != 8'hff) begin
          bitpos_reg <= bitpos_reg + 8'h01;
          if (over && dur_reg != 8'hff) begin
            dur_reg <= dur_reg + 8'h01;
          end
        end
        if (over && !seen_reg) begin
          seen_reg  <= 1'b1;
          first_reg <= bitpos_reg;
        end
        if (err_rise && !viol_seen_reg) begin
          viol_seen_reg <= 1'b1;
          viol_reg      <= bitpos_reg;
        end
      end else if (rx_fall) begin
        bitpos_reg <= 8'h00;                             // Positions restart per packet
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Second interrupt register: set wins over a same-cycle clear
  // ----------------------------------------------------------------------------
  reg [7:0] irq2_reg;
  wire      coll_evt = mon_reg && rx_s && over && !seen_reg;
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      irq2_reg <= 8'h00;
    end else begin
      irq2_reg[`AMR_IRQ2_CMD_BIT]  <= conv_done |
                                      (irq2_reg[`AMR_IRQ2_CMD_BIT] & ~clr_rise);
      irq2_reg[`AMR_IRQ2_COLL_BIT] <= coll_evt |
                                      (irq2_reg[`AMR_IRQ2_COLL_BIT] & ~clr_rise);
    end
  end

  // ----------------------------------------------------------------------------
  // Display composition and read port
  // ----------------------------------------------------------------------------
  wire [7:0] status_disp = {4'h0, conv_busy, above_reg, mon_reg, phase_reg & phase_ok_reg};
  reg  [7:0] rssi_disp;
  reg  [7:0] rd_next;

  always @* begin
    if (page2b == `AMR_PAGE_PILOT) begin
      rssi_disp = pilot_lvl_reg;
    end else if (page2b == `AMR_PAGE_DATA) begin
      rssi_disp = data_lvl_reg;
    end else if (page2b == `AMR_PAGE_MAX) begin
      rssi_disp = max_lvl_reg;
    end else if (page2b == `AMR_PAGE_FIRST) begin
      rssi_disp = first_reg;
    end else if (page2b == `AMR_PAGE_DUR) begin
      rssi_disp = dur_reg;
    end else if (page2b == `AMR_PAGE_VIOL) begin
      rssi_disp = viol_reg;
    end else begin
      rssi_disp = 8'h00;
    end
  end

  // Unmapped addresses read as zero
  always @* begin
    if (REG_ADDR == `AMR_ADDR_MEAS_SEL) begin
      rd_next = meas_sel_reg;
    end else if (REG_ADDR == `AMR_ADDR_COLL_THR) begin
      rd_next = coll_thr_reg;
    end else if (REG_ADDR == `AMR_ADDR_PAGE_SEL) begin
      rd_next = page_sel_reg;
    end else if (REG_ADDR == `AMR_ADDR_STATUS_DISP) begin
      rd_next = status_disp;
    end else if (REG_ADDR == `AMR_ADDR_RSSI_DISP) begin
      rd_next = rssi_disp;
    end else if (REG_ADDR == `AMR_ADDR_RESULT_DISP) begin
      rd_next = (page2d == `AMR_PAGE_RESULT) ? conv_result : 8'h00;
    end else if (REG_ADDR == `AMR_ADDR_IRQ2) begin
      rd_next = irq2_reg;
    end else begin
      rd_next = 8'h00;
    end
  end

  // ----------------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------------
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      REG_RDATA   <= 8'h00;
      RD_VALID    <= 1'b0;
      SRC_SEL     <= 4'h0;
      IRQ         <= 1'b0;
      pilot_d_reg <= 1'b0;
      data_d_reg  <= 1'b0;
      tick_d_reg  <= 1'b0;
      err_d_reg   <= 1'b0;
      rx_d_reg    <= 1'b0;
      clr_d_reg   <= 1'b0;
    end else begin
      RD_VALID    <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rd_next;
      end
      SRC_SEL     <= msel;
      IRQ         <= |irq2_reg;
      pilot_d_reg <= pilot_s;
      data_d_reg  <= data_s;
      tick_d_reg  <= tick_s;
      err_d_reg   <= err_s;
      rx_d_reg    <= rx_s;
      clr_d_reg   <= irqclr_s;
    end
  end

endmodule

`default_nettype wire

/* verilog/amr_defines.vh */
// Register offsets, field positions, codes and timing counts of the measurement block
`ifndef AMR_DEFINES_VH
`define AMR_DEFINES_VH

// ----------------------------------------------------------------------------
// Register addresses (6 bit)
// ----------------------------------------------------------------------------
`define AMR_ADDR_MEAS_SEL       6'h10
`define AMR_ADDR_COLL_THR       6'h1d
`define AMR_ADDR_PAGE_SEL       6'h29
`define AMR_ADDR_STATUS_DISP    6'h2a
`define AMR_ADDR_RSSI_DISP      6'h2b
`define AMR_ADDR_RESULT_DISP    6'h2d
`define AMR_ADDR_IRQ2           6'h38

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define AMR_RST_MEAS_SEL        8'h00
`define AMR_RST_COLL_THR        8'h00
`define AMR_RST_PAGE_SEL        8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AMR_MSEL_HI             3
`define AMR_MSEL_LO             0
`define AMR_THR_HI              3
`define AMR_THR_LO              0
`define AMR_PAGE2D_HI           5
`define AMR_PAGE2D_LO           4
`define AMR_PAGE2B_HI           3
`define AMR_PAGE2B_LO           0
`define AMR_PHASE_BIT           0
`define AMR_MON_BIT             1
`define AMR_ABOVE_BIT           2
`define AMR_BUSY_BIT            3
`define AMR_IRQ2_CMD_BIT        0
`define AMR_IRQ2_COLL_BIT       1

// ----------------------------------------------------------------------------
// Source-select codes
// ----------------------------------------------------------------------------
`define AMR_SRC_CARRIER         4'h4
`define AMR_SRC_EXT_SUPPLY      4'h7
`define AMR_SRC_DIG_SUPPLY      4'h8
`define AMR_SRC_EXT_AMP         4'h9
`define AMR_SRC_INT_AMP         4'ha
`define AMR_SRC_LIN_I           4'hb
`define AMR_SRC_LIN_Q           4'hc

// ----------------------------------------------------------------------------
// Direct commands and pages
// ----------------------------------------------------------------------------
`define AMR_CMD_CONVERT         8'h87
`define AMR_CMD_COLL_ON         8'haa
`define AMR_CMD_COLL_OFF        8'hab
`define AMR_PAGE_RESULT         2'h0
`define AMR_PAGE_PILOT          4'h0
`define AMR_PAGE_DATA           4'h1
`define AMR_PAGE_MAX            4'h2
`define AMR_PAGE_FIRST          4'h3
`define AMR_PAGE_DUR            4'h4
`define AMR_PAGE_VIOL           4'h5

// ----------------------------------------------------------------------------
// Timing: conversion time in ns and derived cycles at 40 ns
// ----------------------------------------------------------------------------
`define AMR_CONV_TIME_NS        20000
`define AMR_CLK_PERIOD_NS       40
`define AMR_CONV_CYCLES         (`AMR_CONV_TIME_NS / `AMR_CLK_PERIOD_NS)
`define AMR_SIGN_POS            8'h80

`endif

/* verilog/amr_sync.v */
// Two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module amr_sync #(
  parameter W = 1
) (
  input  wire         clk,     // Block clock
  input  wire         rst,     // Async reset, high
  input  wire [W-1:0] d,       // Asynchronous levels
  output reg  [W-1:0] q        // Synchronised levels
);

  reg [W-1:0] meta_reg;

  // ----------------------------------------------------------------------------
  // Stage one feeds only stage two
  // ----------------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

`default_nettype wire

/* verilog/amr_adc_core.v */
// Converter sequencer: timed conversion and sign-magnitude coding of one sample
`timescale 1ns/1ps
`default_nettype none

`include "amr_defines.vh"

module amr_adc_core (
  input  wire       clk,         // Block clock
  input  wire       rst,         // Async reset, high
  input  wire       start,       // One-cycle conversion start
  input  wire [7:0] sample,      // Offset-binary sample, 80h = centre
  output reg        busy,        // Conversion running
  output reg        done,        // One-cycle completion pulse
  output reg  [7:0] result       // Sign-magnitude result
);

  localparam integer CONV_CYCLES = `AMR_CONV_CYCLES;
  localparam [9:0]   CONV_LAST   = CONV_CYCLES[9:0] - 10'd1;

  reg [9:0] cnt_reg;
  reg [7:0] held_reg;
  reg [7:0] code;

  // ----------------------------------------------------------------------------
  // Offset binary to sign-magnitude, magnitude clipped at 127
  // ----------------------------------------------------------------------------
  always @* begin
    if (held_reg >= `AMR_SIGN_POS) begin
      code = {1'b1, held_reg[6:0]};
    end else if (held_reg == 8'h00) begin
      code = 8'h7f;                                    // Clip: -128 reads as -127
    end else begin
      code = {1'b0, 7'h00 - held_reg[6:0]};
    end
  end

  // ----------------------------------------------------------------------------
  // Sample held at start so a moving input cannot skew the result
  // ----------------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 10'h000;
      held_reg <= 8'h80;
      busy     <= 1'b0;
      done     <= 1'b0;
      result   <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        held_reg <= sample;
        cnt_reg  <= 10'h000;
        busy     <= 1'b1;
      end else if (busy) begin
        if (cnt_reg == CONV_LAST) begin
          busy   <= 1'b0;
          done   <= 1'b1;
          result <= code;
        end else begin
          cnt_reg <= cnt_reg + 10'h001;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* verification/amr_host_model.sv */
// Host model: register transfers and direct commands
`timescale 1ns/1ps
`default_nettype none
module amr_host_model (
  input  wire logic       clk,   // Clock
  output var  logic       wr,    // Write strobe
  output var  logic       rd,    // Read strobe
  output var  logic [5:0] addr,  // Address
  output var  logic [7:0] wdata, // Write data
  output var  logic       stb,   // Command strobe
  output var  logic [7:0] code   // Command code
);
  // Bus idle at start
  initial begin
    {wr, rd, stb, addr, wdata, code} = '0;
  end
  // Held across one rising edge, then parked inverted so stale values never match
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    begin
      @(negedge clk);
      {wr, rd, addr, wdata} = {w, ~w, a, d};
      @(negedge clk);
      {wr, rd, addr, wdata} = {2'b00, ~a, ~d};
    end
  endtask
  // One direct command strobe
  task automatic cmd(input logic [7:0] c);
    begin
      @(negedge clk);
      {stb, code} = {1'b1, c};
      @(negedge clk);
      {stb, code} = {1'b0, ~c};
    end
  endtask
endmodule
`default_nettype wire

/* verification/amr_top_monitor.sv */
// Port checker for the measurement block
`timescale 1ns/1ps
`default_nettype none
module amr_top_monitor (
  input wire logic       REF_CLK,   // Clock
  input wire logic       RESET,     // Reset
  input wire logic       REG_WR,    // Write
  input wire logic       REG_RD,    // Read
  input wire logic [5:0] REG_ADDR,  // Address
  input wire logic [7:0] REG_WDATA, // Write data
  input wire logic       CMD_STB,   // Command
  input wire logic [7:0] CMD_CODE,  // Code
  input wire logic [7:0] REG_RDATA, // Read data
  input wire logic       RD_VALID,  // Read valid
  input wire logic       IRQ        // Interrupt
);
  logic [9:0] cnt_reg;  // Cycles since convert
  logic [1:0] page_reg; // Result page
  logic       mon_reg;  // Monitor on
  // Host-side shadows; a convert while counting is dropped
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cnt_reg  <= 10'h000;
      page_reg <= 2'h0;
      mon_reg  <= 1'b0;
    end else begin
      if (cnt_reg != 10'h000)
        cnt_reg <= (cnt_reg == 10'h1f7) ? 10'h000 : cnt_reg + 10'h001;
      else if (CMD_STB && CMD_CODE == 8'h87)
        cnt_reg <= 10'h001;
      if (REG_WR && REG_ADDR == 6'h29)
        page_reg <= REG_WDATA[5:4];
      if (CMD_STB && CMD_CODE[7:1] == 7'h55)
        mon_reg <= ~CMD_CODE[0];
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // A read request at one address
  sequence rd_at(logic [5:0] a);
    REG_RD && REG_ADDR == a;
  endsequence
  AST_RD_ANSWER: assert property (REG_RD |=> RD_VALID)
    else $error("read not answered");
  AST_RD_ONLY: assert property (RD_VALID |-> $past(REG_RD))
    else $error("stray read valid");
  AST_RD_HOLD: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
    else $error("read data moved");
  AST_PAGE_BLANK: assert property (rd_at(6'h2d) ##0 page_reg != 2'h0 |=> REG_RDATA == 8'h00)
    else $error("result shown on wrong page");
  AST_UNMAPPED: assert property (rd_at(6'h3f) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_MON_BIT: assert property (rd_at(6'h2a) |=> REG_RDATA[1] == mon_reg)
    else $error("monitor bit wrong");
  AST_CONV_DONE: assert property (cnt_reg == 10'h1f7 |-> $rose(IRQ))
    else $error("conversion flag late");
  AST_CONV_EARLY: assert property (cnt_reg != 10'h000 && cnt_reg < 10'h1f7 |-> !$rose(IRQ))
    else $error("conversion flag early");
endmodule
`default_nettype wire

/* verification/test_amr_top.sv */
// Bench: source conversions, held I/Q levels, collision monitor, register access
`timescale 1ns/1ps
`default_nettype none
module test_amr_top;
  logic            REF_CLK = 1'b0, RESET = 1'b1, RX_ACTIVE = 1'b0, PILOT_END = 1'b0;
  logic            SUBC_INPHASE = 1'b1, IRQ_CLR = 1'b0, DATA_MARK = 1'b0;
  logic            BIT_TICK = 1'b0, PROTO_ERR = 1'b0; // Ticks pulsed in the collision test
  logic [7:0]      LIN_I = 8'h00, LIN_Q = 8'hfe, ENV_LEVEL = 8'h00, rnd = 8'h3d;
  logic [5:0][7:0] ain = '0; // Sources, carrier first
  logic [3:0]      srcs [6] = '{4'h4, 4'h7, 4'h8, 4'h9, 4'ha, 4'h0};
  logic [7:0]      exp_q [$];
  logic [5:0]      adr_q [$];
  int              error_cnt = 0, checks = 0;
  wire             REG_WR, REG_RD, CMD_STB, RD_VALID, IRQ;
  wire [5:0]       REG_ADDR;
  wire [7:0]       REG_WDATA, CMD_CODE, REG_RDATA;
  wire [3:0]       SRC_SEL;
  wire [7:0]       AIN_CARRIER = ain[0], AIN_EXT = ain[1], AIN_DIG = ain[2];
  wire [7:0]       AIN_EXT_AMP = ain[3], AIN_INT_AMP = ain[4], AIN_OTHER = ain[5];
  amr_host_model amr_host_model_i (.clk(REF_CLK), .wr(REG_WR), .rd(REG_RD),
    .addr(REG_ADDR), .wdata(REG_WDATA), .stb(CMD_STB), .code(CMD_CODE));
  amr_top amr_top_i (.*);
  always #20 REF_CLK = ~REF_CLK; // 25 MHz
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Sign-magnitude of an offset sample; zero saturates at -127
  function automatic logic [7:0] enc(input logic [7:0] v);
    enc = v[7] ? v : (v == 8'h00 ? 8'h7f : 8'h80 - v);
  endfunction
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    begin
      checks++;
      if (g !== e) begin
        error_cnt++;
        $display("MISMATCH %s exp %h got %h", n, e, g);
      end
    end
  endtask
  // Each answered read is checked against the oldest note
  always @(negedge REF_CLK) begin
    if (RD_VALID === 1'b1)
      cmp($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(), REG_RDATA);
  end
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    begin
      exp_q.push_back(e);
      adr_q.push_back(a);
      amr_host_model_i.xfer(1'b0, a, 8'h00);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    amr_host_model_i.xfer(1'b1, a, d);
  endtask
  // Bounded wait for the request, flag check, then clear
  task automatic irq_done(input logic [7:0] f);
    int n;
    begin
      for (n = 0; n < 700 && IRQ !== 1'b1; n++)
        @(negedge REF_CLK);
      cmp("IRQ", 8'h01, {7'h00, IRQ});
      rd(6'h38, f);
      IRQ_CLR = 1'b1;
      repeat (2) @(negedge REF_CLK);
      IRQ_CLR = 1'b0;
      repeat (8) @(negedge REF_CLK);
      cmp("IRQ", 8'h00, {7'h00, IRQ});
    end
  endtask
  // Second convert lands while busy and must be ignored
  task automatic conv(input logic [3:0] s, input logic [7:0] e);
    begin
      wr(6'h10, {4'h0, s});
      amr_host_model_i.cmd(8'h87);
      cmp("SRC_SEL", {4'h0, s}, {4'h0, SRC_SEL});
      amr_host_model_i.cmd(8'h87);
      irq_done(8'h01);
      rd(6'h2d, e);
    end
  endtask
  task automatic final_report;
    begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Main sequence
  initial begin
    repeat (5) @(negedge REF_CLK);
    RESET = 1'b0;
    rd(6'h10, 8'h00);
    rd(6'h3f, 8'h00);
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 6; j++) begin
        rnd = lfsr(rnd);
        ain[j] = rnd;
      end
      conv(srcs[k], enc(ain[k]));
    end
    wr(6'h2d, 8'hff);
    wr(6'h10, 8'h00);
    rd(6'h2d, enc(ain[5]));
    wr(6'h29, 8'h10);
    rd(6'h2d, 8'h00);
    wr(6'h29, 8'h00);
    $display("test sources done");
    RX_ACTIVE = 1'b1;
    PILOT_END = 1'b1;
    repeat (2) @(negedge REF_CLK);
    PILOT_END = 1'b0;
    repeat (4) @(negedge REF_CLK);
    {LIN_I, LIN_Q} = 16'h5522; // Live levels move; only the held pair counts
    rd(6'h2a, 8'h01);
    conv(4'hb, 8'h7f);
    conv(4'hc, 8'hff);
    RX_ACTIVE = 1'b0;
    repeat (4) @(negedge REF_CLK);
    rd(6'h2a, 8'h00);
    $display("test linear done");
    wr(6'h1d, 8'hf5);
    amr_host_model_i.cmd(8'haa);
    rd(6'h2a, 8'h02);
    RX_ACTIVE = 1'b1;
    ENV_LEVEL = 8'h50;
    repeat (6) @(negedge REF_CLK);
    rd(6'h38, 8'h00);
    // Three bits pass at threshold without exceeding it, so the first exceedance sits at bit 3
    repeat (3) begin
      BIT_TICK = 1'b1;
      repeat (2) @(negedge REF_CLK);
      BIT_TICK = 1'b0;
      repeat (2) @(negedge REF_CLK);
    end
    ENV_LEVEL = 8'h60;
    irq_done(8'h02);
    wr(6'h29, 8'h03);
    rd(6'h2b, 8'h03);
    wr(6'h29, 8'h02);
    rd(6'h2b, 8'h60);
    {RX_ACTIVE, ENV_LEVEL} = 9'h000;
    amr_host_model_i.cmd(8'hab);
    rd(6'h2a, 8'h00);
    for (int p = 2; p < 6; p++) begin
      wr(6'h29, p[7:0]);
      rd(6'h2b, 8'h00);
    end
    $display("test collision done");
    repeat (4) @(negedge REF_CLK);
    final_report;
  end
  // Watchdog: about three times the expected run
  initial begin
    #(40 * 12000);
    error_cnt++;
    final_report;
  end
endmodule
bind amr_top amr_top_monitor amr_top_monitor_i (.*);
`default_nettype wire
